// ---- rtl/asp_uart.sv ----
`timescale 1ns/100ps
`default_nettype none
module asp_uart #(
  parameter int DEPTH = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        serial_in,
  output logic             serial_out
);
  import asp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // software registers
  asp_ctl_t    ctl_r;
  logic [15:0] idiv_r;
  logic [5:0]  fdiv_r;
  asp_lcr_t    lcr_r;
  asp_work_t   work_r;
  logic [5:0]  fls_r;
  logic [7:0]  lpd_r;
  // bus
  logic        a_wr_r;
  logic [7:0]  a_addr_r;
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        serial_out_r;
  // queues
  logic [7:0]  txm [DEPTH];
  asp_rxw_t    rxm [DEPTH];
  logic [AW-1:0] txw_r, txr_r, rxw_r, rxr_r;
  logic [AW:0] txn_r, rxn_r;
  logic        ovr_r;
  // timing
  logic [22:0] acc_r;
  logic        tick_r;
  logic [7:0]  lpc_r;
  logic [1:0]  pw_r;
  logic [3:0]  irh_r;
  // transmitter
  asp_st_t     tst_r, tst_nxt;
  logic [3:0]  tcnt_r, tcnt_nxt;
  logic [2:0]  tbit_r, tbit_nxt;
  logic [7:0]  tsh_r, tsh_nxt;
  logic        tpar_r, tpar_nxt, t2_r, t2_nxt, tx_pop;
  // receiver
  asp_st_t     rst_r, rst_nxt;
  logic [3:0]  rcnt_r, rcnt_nxt;
  logic [2:0]  rbit_r, rbit_nxt;
  logic [7:0]  rsh_r, rsh_nxt;
  logic        rz_r, rz_nxt, rpe_r, rpe_nxt, rx_push;

  // parity bit for the selected mode
  function automatic logic parb(input logic [7:0] d, input asp_lcr_t l);
    parb = l.sps ? !l.eps : (l.eps ? ^d : !(^d));
  endfunction

  // queue trigger levels in eighths of the depth
  function automatic logic [AW:0] thr(input logic [2:0] s);
    logic [AW+3:0] d;
    d = (AW+4)'(DEPTH);
    case (s)
      3'h0: thr = (AW+1)'(d >> 3);
      3'h1: thr = (AW+1)'(d >> 2);
      3'h3: thr = (AW+1)'((d * 3) >> 2);
      3'h4: thr = (AW+1)'((d * 7) >> 3);
      default: thr = (AW+1)'(d >> 1);
    endcase
  endfunction

  // address phase taken, data phase decode
  wire logic take_w  = hsel && hready && htrans[1];
  wire logic rd_take = take_w && !hwrite;
  wire logic wr_data = a_wr_r && a_addr_r == A_DATA;
  wire logic wr_idiv = a_wr_r && a_addr_r == A_IDIV;
  wire logic wr_fdiv = a_wr_r && a_addr_r == A_FDIV;
  wire logic wr_lcr  = a_wr_r && a_addr_r == A_LCR;
  wire logic wr_ctl  = a_wr_r && a_addr_r == A_CTL;
  wire logic wr_fls  = a_wr_r && a_addr_r == A_FLS;
  wire logic wr_lpd  = a_wr_r && a_addr_r == A_LPD;

  // queue state; fen clear shrinks both queues to one entry
  wire asp_lcr_t   lc_w     = work_r.lcr;
  wire logic [AW:0] cap_w   = lc_w.fen ? (AW+1)'(DEPTH) : (AW+1)'(1);
  wire logic tx_empty = txn_r == '0;
  wire logic tx_full  = txn_r >= cap_w;
  wire logic rx_empty = rxn_r == '0;
  wire logic rx_full  = rxn_r >= cap_w;
  wire logic tx_push  = wr_data && !tx_full;
  wire logic rx_ok    = rx_push && !rx_full;
  wire logic rx_pop   = rd_take && haddr[7:0] == A_DATA && !rx_empty;
  wire logic tx_lvl   = txn_r <= thr(fls_r[2:0]);
  wire logic rx_lvl   = rxn_r >= thr(fls_r[5:3]);
  wire logic busy_w   = !tx_empty || tst_r != ST_IDLE;

  // read mux, registered in the address phase
  wire logic [6:0] stat_w = {rx_lvl, tx_lvl, tx_empty, rx_full,
                             tx_full, rx_empty, busy_w};
  wire logic [7:0] ra_w = haddr[7:0];
  wire logic [31:0] rd_w =
    ra_w == A_DATA ? {20'h0_0000, rx_empty ? 12'h000 : rxm[rxr_r]} :
    ra_w == A_STAT ? {25'h000_0000, stat_w} :
    ra_w == A_IDIV ? {16'h0000, idiv_r} :
    ra_w == A_FDIV ? {26'h000_0000, fdiv_r} :
    ra_w == A_LCR  ? {24'h00_0000, lcr_r} :
    ra_w == A_CTL  ? {16'h0000, ctl_r} :
    ra_w == A_FLS  ? {26'h000_0000, fls_r} :
    ra_w == A_LPD  ? {24'h00_0000, lpd_r} : 32'h0000_0000;

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr_r      <= 1'b0;
      a_addr_r    <= 8'h00;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      a_wr_r      <= take_w && hwrite;
      if (take_w) a_addr_r <= haddr[7:0];
      if (rd_take) hrdata_r <= rd_w;
    end
  end

  // configuration; divisor reaches the working copy only on lcr write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r  <= asp_ctl_t'(CTL_RST);
      idiv_r <= 16'h0000;
      fdiv_r <= 6'h00;
      lcr_r  <= asp_lcr_t'(8'h00);
      work_r <= asp_work_t'(30'h0000_0000);
      fls_r  <= FLS_RST;
      lpd_r  <= 8'h00;
    end else begin
      if (wr_ctl) ctl_r <= asp_ctl_t'(hwdata[15:0]);
      if (wr_idiv) idiv_r <= hwdata[15:0];
      if (wr_fdiv) fdiv_r <= hwdata[5:0];
      if (wr_fls) fls_r <= hwdata[5:0];
      if (wr_lpd) lpd_r <= hwdata[7:0];
      if (wr_lcr) begin
        lcr_r  <= asp_lcr_t'(hwdata[7:0]);
        work_r <= {idiv_r, fdiv_r, hwdata[7:0]};
      end
    end
  end

  // receive line: infrared pulses stretched to a bit; half-duplex in infrared mode
  wire logic rin_w  = ctl_r.sir ? serial_in && irh_r == 4'h0 : serial_in;
  wire logic r_ok   = ctl_r.en && ctl_r.receive_enable_bit &&
                      !(ctl_r.sir && tst_r != ST_IDLE);
  wire logic [7:0] rdat_w = rsh_r >> (2'h3 - lc_w.wlen);

  // queue storage, data only so no reset
  always_ff @(posedge hclk) begin
    if (tx_push) txm[txw_r] <= hwdata[7:0];
    if (rx_ok) rxm[rxw_r] <= {ovr_r, rz_r && !rin_w, rpe_r, !rin_w,
                              rdat_w};
  end

  // queue pointers; a full receive queue drops the word, flags overrun
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txw_r <= '0;
      txr_r <= '0;
      rxw_r <= '0;
      rxr_r <= '0;
      txn_r <= '0;
      rxn_r <= '0;
      ovr_r <= 1'b0;
    end else begin
      if (tx_push) txw_r <= txw_r + AW'(1);
      if (tx_pop) txr_r <= txr_r + AW'(1);
      if (rx_ok) rxw_r <= rxw_r + AW'(1);
      if (rx_pop) rxr_r <= rxr_r + AW'(1);
      txn_r <= txn_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      rxn_r <= rxn_r + (AW+1)'(rx_ok) - (AW+1)'(rx_pop);
      if (rx_push && rx_full) ovr_r <= 1'b1;
      else if (rx_ok) ovr_r <= 1'b0;
    end
  end

  // fractional 16x tick: add 64 per clock, subtract divisor on wrap;
  // keeps running while a character is still in flight
  wire logic [22:0] div_w = {1'b0, work_r.idiv, work_r.fdiv};
  wire logic [22:0] dv_w  = div_w < FRAC_ONE ? FRAC_ONE : div_w;
  wire logic [22:0] sum_w = acc_r + FRAC_ONE;
  wire logic run_w = ctl_r.en || tst_r != ST_IDLE || rst_r != ST_IDLE;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r  <= 23'h00_0000;
      tick_r <= 1'b0;
    end else if (!run_w) begin
      acc_r  <= 23'h00_0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= sum_w >= dv_w;
      acc_r  <= sum_w >= dv_w ? sum_w - dv_w : sum_w;
    end
  end

  // character layout
  wire logic [2:0] lastb_w = {1'b0, lc_w.wlen} + 3'h4;
  wire logic [7:0] mask_w  = 8'hFF >> (2'h3 - lc_w.wlen);
  wire logic [7:0] tnew_w  = txm[txr_r] & mask_w;

  // transmitter
  always_comb begin
    tst_nxt  = tst_r;
    tcnt_nxt = tcnt_r;
    tbit_nxt = tbit_r;
    tsh_nxt  = tsh_r;
    tpar_nxt = tpar_r;
    t2_nxt   = t2_r;
    tx_pop   = 1'b0;
    case (tst_r)
      ST_IDLE: if (ctl_r.en && ctl_r.transmit_enable_bit && !tx_empty) begin
        tx_pop   = 1'b1;
        tsh_nxt  = tnew_w;
        tpar_nxt = parb(tnew_w, lc_w);
        tst_nxt  = ST_START;
        tcnt_nxt = 4'h0;
        t2_nxt   = 1'b0;
      end
      default: if (tick_r) begin
        tcnt_nxt = tcnt_r + 4'h1;
        if (tcnt_r == BIT_LAST) begin
          case (tst_r)
            ST_START: begin
              tst_nxt  = ST_DATA;
              tbit_nxt = 3'h0;
            end
            ST_DATA: begin
              tsh_nxt  = tsh_r >> 1;
              tbit_nxt = tbit_r + 3'h1;
              if (tbit_r == lastb_w) tst_nxt = lc_w.pen ? ST_PAR : ST_STOP;
            end
            ST_PAR: tst_nxt = ST_STOP;
            default: if (lc_w.stp2 && !t2_r) t2_nxt = 1'b1;
                     else tst_nxt = ST_IDLE;
          endcase
        end
      end
    endcase
  end

  // line level, break and infrared pulse shaping
  wire logic tbit_w = tst_r == ST_START ? 1'b0 :
                      tst_r == ST_DATA  ? tsh_r[0] :
                      tst_r == ST_PAR   ? tpar_r : 1'b1;
  wire logic line_w = tbit_w && !lc_w.brk;
  wire logic lp_w   = lpc_r == lpd_r;
  wire logic bnd_w  = tx_pop || (tick_r && tcnt_r == BIT_LAST);
  wire logic sirp_w = !line_w && (ctl_r.sirlp ? pw_r != 2'h0
                                              : tcnt_r < SIR_WIDTH);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out_r <= 1'b1;
      lpc_r        <= 8'h00;
      pw_r         <= 2'h0;
    end else begin
      serial_out_r <= ctl_r.sir ? sirp_w : line_w;
      lpc_r        <= lp_w ? 8'h00 : lpc_r + 8'h01;
      if (bnd_w) pw_r <= LP_PULSE;
      else if (lp_w && pw_r != 2'h0) pw_r <= pw_r - 2'h1;
    end
  end

  // receiver
  always_comb begin
    rst_nxt  = rst_r;
    rcnt_nxt = rcnt_r;
    rbit_nxt = rbit_r;
    rsh_nxt  = rsh_r;
    rz_nxt   = rz_r;
    rpe_nxt  = rpe_r;
    rx_push  = 1'b0;
    if (tick_r) begin
      case (rst_r)
        ST_IDLE: if (r_ok && !rin_w) begin
          rst_nxt  = ST_START;
          rcnt_nxt = 4'h0;
          rz_nxt   = 1'b1;
          rpe_nxt  = 1'b0;
        end
        default: begin
          rcnt_nxt = rcnt_r + 4'h1;
          if (rst_r == ST_START) begin
            if (rcnt_r == START_SAMPLE) begin
              rcnt_nxt = 4'h0;
              rbit_nxt = 3'h0;
              rst_nxt  = rin_w ? ST_IDLE : ST_DATA;
            end
          end else if (rcnt_r == BIT_LAST) begin
            case (rst_r)
              ST_DATA: begin
                rsh_nxt  = {rin_w, rsh_r[7:1]};
                rz_nxt   = rz_r && !rin_w;
                rbit_nxt = rbit_r + 3'h1;
                if (rbit_r == lastb_w)
                  rst_nxt = lc_w.pen ? ST_PAR : ST_STOP;
              end
              ST_PAR: begin
                rpe_nxt = rin_w != parb(rdat_w, lc_w);
                rz_nxt  = rz_r && !rin_w;
                rst_nxt = ST_STOP;
              end
              default: begin
                rx_push = 1'b1;
                rst_nxt = ST_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // state registers of both directions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tst_r  <= ST_IDLE;
      tcnt_r <= 4'h0;
      tbit_r <= 3'h0;
      tsh_r  <= 8'h00;
      tpar_r <= 1'b0;
      t2_r   <= 1'b0;
      rst_r  <= ST_IDLE;
      rcnt_r <= 4'h0;
      rbit_r <= 3'h0;
      rsh_r  <= 8'h00;
      rz_r   <= 1'b0;
      rpe_r  <= 1'b0;
      irh_r  <= 4'h0;
    end else begin
      tst_r  <= tst_nxt;
      tcnt_r <= tcnt_nxt;
      tbit_r <= tbit_nxt;
      tsh_r  <= tsh_nxt;
      tpar_r <= tpar_nxt;
      t2_r   <= t2_nxt;
      rst_r  <= rst_nxt;
      rcnt_r <= rcnt_nxt;
      rbit_r <= rbit_nxt;
      rsh_r  <= rsh_nxt;
      rz_r   <= rz_nxt;
      rpe_r  <= rpe_nxt;
      if (!serial_in) irh_r <= BIT_LAST;
      else if (tick_r && irh_r != 4'h0) irh_r <= irh_r - 4'h1;
    end
  end

  assign hreadyout  = hreadyout_r;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;
  assign serial_out = serial_out_r;

  // checks
  property p_ctl_reset;
    @(posedge hclk) disable iff (!hresetn)
    !$past(hresetn) |-> ctl_r.transmit_enable_bit && ctl_r.receive_enable_bit;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("enables not set after reset");

  property p_div_hold;
    @(posedge hclk) disable iff (!hresetn)
    (wr_idiv || wr_fdiv) |=> $stable(work_r);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divisor applied without line write");

  property p_div_load;
    @(posedge hclk) disable iff (!hresetn)
    wr_lcr |=> work_r.idiv == $past(idiv_r) &&
               work_r.fdiv == $past(fdiv_r);
  endproperty
  a_div_load: assert property (p_div_load)
    else $error("divisor not loaded on line write");

  property p_idle_high;
    @(posedge hclk) disable iff (!hresetn)
    tst_r == ST_IDLE && !lc_w.brk && !ctl_r.sir |=> serial_out;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("idle line not high");

  property p_start_low;
    @(posedge hclk) disable iff (!hresetn)
    tst_r == ST_START && !lc_w.brk && !ctl_r.sir |=> !serial_out;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_hold_gen;
    @(posedge hclk) disable iff (!hresetn)
    !run_w |=> acc_r == 23'h00_0000 && !tick_r;
  endproperty
  a_hold_gen: assert property (p_hold_gen)
    else $error("tick generator runs while disabled");

  property p_false_start;
    @(posedge hclk) disable iff (!hresetn)
    rst_r == ST_START && tick_r && rcnt_r == START_SAMPLE && rin_w
      |=> rst_r == ST_IDLE;
  endproperty
  a_false_start: assert property (p_false_start)
    else $error("false start not ignored");

  property p_busy;
    @(posedge hclk) disable iff (!hresetn)
    tx_push |=> busy_w;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not raised on queue write");

  property p_bit_len;
    @(posedge hclk) disable iff (!hresetn)
    tst_r == ST_START && tick_r && tcnt_r == BIT_LAST
      |=> tst_r == ST_DATA && tcnt_r == 4'h0;
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("start bit not sixteen ticks");

endmodule
`default_nettype wire

// ---- rtl/asp_pkg.sv ----
package asp_pkg;

  // register byte offsets
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_IDIV = 8'h08;
  localparam logic [7:0] A_FDIV = 8'h0C;
  localparam logic [7:0] A_LCR  = 8'h10;
  localparam logic [7:0] A_CTL  = 8'h14;
  localparam logic [7:0] A_FLS  = 8'h18;
  localparam logic [7:0] A_LPD  = 8'h1C;

  // reset values: both directions enabled, port off, half-depth levels
  localparam logic [15:0] CTL_RST = 16'h0300;
  localparam logic [5:0]  FLS_RST = 6'h12;

  // tick counts inside one bit period, low-power pulse length and the fractional divisor unit
  localparam logic [3:0]  BIT_LAST     = 4'hF;
  localparam logic [3:0]  START_SAMPLE = 4'h7;
  localparam logic [3:0]  SIR_WIDTH    = 4'h3;
  localparam logic [1:0]  LP_PULSE     = 2'h3;
  localparam logic [22:0] FRAC_ONE     = 23'h00_0040;

  // line control word
  typedef struct packed {
    logic       sps;
    logic [1:0] wlen;
    logic       fen;
    logic       stp2;
    logic       eps;
    logic       pen;
    logic       brk;
  } asp_lcr_t;

  // 30-bit working register: divisor and line control together
  typedef struct packed {
    logic [15:0] idiv;
    logic [5:0]  fdiv;
    asp_lcr_t    lcr;
  } asp_work_t;

  // received word with its status
  typedef struct packed {
    logic       oe;
    logic       be;
    logic       pe;
    logic       fe;
    logic [7:0] data;
  } asp_rxw_t;

  // port control word
  typedef struct packed {
    logic [5:0] rsv_hi;
    logic       receive_enable_bit;
    logic       transmit_enable_bit;
    logic [4:0] rsv_lo;
    logic       sirlp;
    logic       sir;
    logic       en;
  } asp_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } asp_st_t;

endpackage

// ---- verification/asp_remote.sv ----
`timescale 1ns/100ps
`default_nettype none
// far-side serial port: sends raw frames and captures the device's frames
module asp_remote (
  input  wire logic hclk,
  input  wire logic serial_out,
  output logic      serial_in
);
  // line idles high, as a released line with pull-up would
  initial serial_in = 1'b1;

  // bits go out lsb first, start bit at index 0
  task automatic send_bits(input logic [15:0] f, input int n, input int bclk);
    for (int i = 0; i < n; i++) begin
      serial_in <= f[i];
      repeat (bclk) @(posedge hclk);
    end
    serial_in <= 1'b1;
  endtask

  // sample mid-bit so a stretched or shrunk bit shows as a wrong value
  task automatic get_frame(input int n, input int bclk, output logic [15:0] f);
    f = '0;
    do @(posedge hclk); while (serial_out !== 1'b0);
    repeat (bclk / 2) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      f[i] = serial_out;
      if (i < n - 1) repeat (bclk) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/asp_uart_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module asp_uart_tb;
  import asp_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        serial_in;
  logic        serial_out;
  int          n_mismatch;
  int          cmp_count;
  logic [31:0] q;
  logic [15:0] f;
  logic [15:0] g;
  int          n;
  // table rows: line control, data, expected received word
  logic [7:0]  lcr_tab [5] = '{8'h70, 8'h16, 8'h3A, 8'hD6, 8'hF2};
  logic [7:0]  dat_tab [5] = '{8'hA5, 8'h13, 8'h2C, 8'h5A, 8'hC3};
  logic [31:0] rx_tab  [5] = '{32'h0000_00A5, 32'h0000_0013, 32'h0000_002C,
                               32'h0000_005A, 32'h0000_00C3};

  asp_uart dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (1'b1),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'b010),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .serial_in (serial_in),
    .serial_out(serial_out)
  );
  asp_remote rem (.hclk(hclk), .serial_out(serial_out), .serial_in(serial_in));

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one single transfer; entered right after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // port is switched off around every reconfiguration
  task automatic cfg(input logic [7:0] lcr, input logic [15:0] idiv);
    bus(A_CTL, 1'b1, 32'h0000_0300, q);
    bus(A_IDIV, 1'b1, {16'h0000, idiv}, q);
    bus(A_FDIV, 1'b1, 32'h0000_0000, q);
    bus(A_LCR, 1'b1, {24'h00_0000, lcr}, q);
    bus(A_CTL, 1'b1, 32'h0000_0301, q);
  endtask

  // expected frame from the line settings, start bit first
  function automatic int mkframe(input logic [7:0] lcr, input logic [7:0] d,
                                 output logic [15:0] fr);
    asp_lcr_t c;
    int       k;
    c  = asp_lcr_t'(lcr);
    fr = '0;
    k  = int'(c.wlen) + 5;
    for (int i = 0; i < k; i++) fr[i + 1] = d[i];
    k = k + 1;
    if (c.pen) begin
      fr[k] = c.sps ? ~c.eps : (c.eps ? ^d : ~^d);
      k = k + 1;
    end
    fr[k] = 1'b1;
    fr[k + 1] = c.stp2;
    return k + (c.stp2 ? 2 : 1);
  endfunction

  // send a faulty frame, compare stored word, then drain any leftovers
  task automatic rxerr(input logic [15:0] fr, input int k,
                       input logic [31:0] e, input string m);
    rem.send_bits(fr, k, 16);
    bus(A_DATA, 1'b0, 0, q);
    chk(q, e, m);
    repeat (300) @(posedge hclk);
    for (int i = 0; i < 4; i++) bus(A_DATA, 1'b0, 0, q);
  endtask

  // watchdog sized well above the expected run length
  initial begin
    #(40000 * 20);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge hclk);
    chk({31'h0, serial_out}, 32'h1, "idle line in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(A_CTL, 1'b0, 0, q);
    chk(q, 32'h0000_0300, "ctl reset");
    bus(A_FLS, 1'b0, 0, q);
    chk(q, 32'h0000_0012, "level reset");
    bus(A_STAT, 1'b0, 0, q);
    chk(q, 32'h0000_0032, "stat reset");
    bus(8'h20, 1'b0, 0, q);
    chk(q, 32'h0000_0000, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "okay response");
    $display("test done: reset values");

    // every length, parity kind and stop count, both directions
    for (int r = 0; r < 5; r++) begin
      cfg(lcr_tab[r], 16'h0001);
      n = mkframe(lcr_tab[r], dat_tab[r], f);
      fork
        rem.get_frame(n, 16, g);
        bus(A_DATA, 1'b1, {24'h00_0000, dat_tab[r]}, q);
      join
      chk({16'h0, g}, {16'h0, f}, "tx frame");
      rem.send_bits(f, n, 16);
      bus(A_DATA, 1'b0, 0, q);
      chk(q, rx_tab[r], "rx word");
    end
    $display("test done: frame table");

    // a short low glitch must not become a character
    cfg(8'h70, 16'h0001);
    rem.send_bits(16'h0000, 1, 4);
    repeat (400) @(posedge hclk);
    bus(A_STAT, 1'b0, 0, q);
    chk(q & 32'h0000_0002, 32'h0000_0002, "false start");
    $display("test done: false start");

    // wrong even parity, low stop, then a break
    cfg(8'h76, 16'h0001);
    rxerr(16'h0402, 11, 32'h0000_0201, "parity error");
    cfg(8'h70, 16'h0001);
    rxerr(16'h00AA, 10, 32'h0000_0155, "framing error");
    rxerr(16'h0000, 10, 32'h0000_0500, "break");
    $display("test done: receive errors");

    // divisor change waits for the line control write
    bus(A_CTL, 1'b1, 32'h0000_0300, q);
    bus(A_IDIV, 1'b1, 32'h0000_0002, q);
    bus(A_CTL, 1'b1, 32'h0000_0301, q);
    n = mkframe(8'h70, 8'h55, f);
    fork
      rem.get_frame(n, 16, g);
      bus(A_DATA, 1'b1, 32'h0000_0055, q);
    join
    chk({16'h0, g}, {16'h0, f}, "old divisor kept");
    repeat (20) @(posedge hclk);
    cfg(8'h70, 16'h0002);
    fork
      rem.get_frame(n, 32, g);
      bus(A_DATA, 1'b1, 32'h0000_0055, q);
    join
    chk({16'h0, g}, {16'h0, f}, "new divisor");
    repeat (40) @(posedge hclk);
    $display("test done: divisor latch");

    // busy while sending; switching off mid-character still ends it
    n = mkframe(8'h70, 8'h3C, f);
    fork
      rem.get_frame(n, 32, g);
      begin
        bus(A_DATA, 1'b1, 32'h0000_003C, q);
        bus(A_STAT, 1'b0, 0, q);
        chk(q & 32'h0000_0001, 32'h0000_0001, "busy set");
        bus(A_CTL, 1'b1, 32'h0000_0300, q);
      end
    join
    chk({16'h0, g}, {16'h0, f}, "finish after disable");
    repeat (40) @(posedge hclk);
    bus(A_STAT, 1'b0, 0, q);
    chk(q & 32'h0000_0001, 32'h0000_0000, "busy clear");
    chk({31'h0, serial_out}, 32'h1, "idle high when off");
    $display("test done: busy and disable");

    // break holds the line low even while idle
    cfg(8'h61, 16'h0001);
    repeat (2) @(posedge hclk);
    chk({31'h0, serial_out}, 32'h0, "break sent");
    $display("test done: break");

    // single-entry queue: second word dropped, next stored word has oe
    cfg(8'h60, 16'h0001);
    n = mkframe(8'h60, 8'h11, f);
    rem.send_bits(f, n, 16);
    @(posedge hclk);
    n = mkframe(8'h60, 8'h22, f);
    rem.send_bits(f, n, 16);
    bus(A_STAT, 1'b0, 0, q);
    chk(q & 32'h0000_000A, 32'h0000_0008, "rx full");
    bus(A_DATA, 1'b0, 0, q);
    chk(q, 32'h0000_0011, "first word kept");
    n = mkframe(8'h60, 8'h33, f);
    rem.send_bits(f, n, 16);
    bus(A_DATA, 1'b0, 0, q);
    chk(q, 32'h0000_0833, "overrun flag");
    $display("test done: overrun");

    // infrared: each zero bit is one high pulse of three ticks
    bus(A_CTL, 1'b1, 32'h0000_0300, q);
    bus(A_CTL, 1'b1, 32'h0000_0303, q);
    bus(A_DATA, 1'b1, 32'h0000_0000, q);
    g = '0;
    repeat (200) begin
      @(posedge hclk);
      g = g + {15'h0000, serial_out};
    end
    chk({16'h0, g}, 32'h0000_001B, "infrared pulses");
    $display("test done: infrared");
    report_and_stop();
  end
endmodule
`default_nettype wire
